/* File: src/dfpa_alu_flags.sv */
module dfpa_alu_flags
   import dfpa_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire dfpa_issue_s issue,
   input wire dfpa_xfer_s xfer,
   output dfpa_flags_s flagsOut,
   output logic saturateEnable,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [BASE_W-1:0] wb_dat_i,
   output logic [BASE_W-1:0] wb_dat_o,
   output logic wb_ack_o
);

   // ==========================================================
   // Elaboration check
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   // ==========================================================
   // State
   dfpa_state_s state_reg;
   dfpa_state_s state_next;

   // ==========================================================
   // Operand extension of every unguarded register
   logic [NUM_REGS-1:0][FULL_W-1:0] extReg;

   for (genvar i = 0; i < NUM_REGS; i++)
   begin : g_ext
      if (i < NUM_GUARDED)
      begin : g_guarded
         assign extReg[i] = state_reg.regs[i];
      end
      else
      begin : g_plain
         assign extReg[i] = {{GUARD_W{state_reg.regs[i][BASE_W-1]}},
            state_reg.regs[i][BASE_W-1:0]};
      end
   end

   // ==========================================================
   // Operand maps
   function automatic dfpa_reg_e mapFirst(input logic [1:0] sel);
      dfpa_reg_e r;
      case (sel)
         2'h0: r = ACC_REG_0;
         2'h1: r = ACC_REG_1;
         2'h2: r = XIN_REG_0;
         default: r = XIN_REG_1;
      endcase
      return r;
   endfunction

   function automatic dfpa_reg_e mapSecond(input logic [1:0] sel);
      dfpa_reg_e r;
      case (sel)
         2'h0: r = YIN_REG_0;
         2'h1: r = YIN_REG_1;
         2'h2: r = MUL_IN_REG_0;
         default: r = MUL_IN_REG_1;
      endcase
      return r;
   endfunction

   function automatic dfpa_reg_e mapAux(input logic [1:0] sel);
      dfpa_reg_e r;
      case (sel)
         2'h0: r = ACC_REG_0;
         2'h1: r = ACC_REG_1;
         2'h2: r = XIN_REG_0;
         default: r = YIN_REG_0;
      endcase
      return r;
   endfunction

   function automatic logic isGuarded(input dfpa_reg_e r);
      return (r == ACC_REG_0) || (r == ACC_REG_1);
   endfunction

   // Loaded word goes to the upper base half, lower half cleared
   function automatic logic [FULL_W-1:0] loadWord(input logic [HALF_W-1:0] d);
      return {{GUARD_W{d[HALF_W-1]}}, d, {HALF_W{1'b0}}};
   endfunction

   // ==========================================================
   // Arithmetic
   logic [FULL_W-1:0] opA;
   logic [FULL_W-1:0] opB;
   logic [FULL_W-1:0] aIn;
   logic [FULL_W-1:0] bIn;
   logic carryIn;
   logic invertCarry;
   logic [BASE_W:0] sumLo;
   logic [GUARD_W:0] sumHi;
   logic [FULL_W-1:0] result;
   logic [FULL_W-1:0] writeVal;
   logic baseCarry;
   logic overRange;
   logic overBase;
   logic resNeg;
   logic resZero;
   logic resGt;
   logic resGe;
   logic srcNeg;
   logic trueSign;
   logic destGuarded;
   logic execute;
   logic updateFlags;
   logic xSlotUsed;
   logic ySlotUsed;
   dfpa_flags_s newFlags;

   always_comb
   begin
      opA = extReg[mapFirst(issue.firstSource)];
      opB = extReg[mapSecond(issue.secondSource)];
      srcNeg = issue.useSecond ? opB[FULL_W-1] : opA[FULL_W-1];
      aIn = '0;
      bIn = '0;
      carryIn = 1'b0;
      invertCarry = 1'b0;
      case (issue.op)
         DSP_ADD:
         begin
            aIn = opA;
            bIn = opB;
         end
         DSP_SUB, DSP_COMPARE:
         begin
            aIn = opA;
            bIn = ~opB;
            carryIn = 1'b1;
            invertCarry = 1'b1;
         end
         DSP_ADD_CARRY:
         begin
            aIn = opA;
            bIn = opB;
            carryIn = state_reg.flags.cond;
         end
         DSP_SUB_BORROW:
         begin
            aIn = opA;
            bIn = ~opB;
            carryIn = ~state_reg.flags.cond;
            invertCarry = 1'b1;
         end
         DSP_COPY:
         begin
            aIn = issue.useSecond ? opB : opA;
         end
         DSP_ABS, DSP_NEG:
         begin
            if (srcNeg || issue.op == DSP_NEG)
            begin
               bIn = issue.useSecond ? ~opB : ~opA;
               carryIn = 1'b1;
               invertCarry = 1'b1;
            end
            else
            begin
               aIn = issue.useSecond ? opB : opA;
            end
         end
         default:
         begin
            aIn = '0;
         end
      endcase
      sumLo = {1'b0, aIn[BASE_W-1:0]} + {1'b0, bIn[BASE_W-1:0]}
         + {{BASE_W{1'b0}}, carryIn};
      sumHi = {1'b0, aIn[FULL_W-1:BASE_W]} + {1'b0, bIn[FULL_W-1:BASE_W]}
         + {{GUARD_W{1'b0}}, sumLo[BASE_W]};
      result = {sumHi[GUARD_W-1:0], sumLo[BASE_W-1:0]};
      baseCarry = (sumLo[BASE_W] ^ invertCarry)
         | (srcNeg && (issue.op == DSP_ABS || issue.op == DSP_NEG));
      overRange = (aIn[FULL_W-1] == bIn[FULL_W-1])
         && (result[FULL_W-1] != aIn[FULL_W-1]);
      overBase = !((&result[FULL_W-1:BASE_W-1]) || !(|result[FULL_W-1:BASE_W-1]));
      resNeg = result[FULL_W-1];
      resZero = (result == '0);
      resGt = ~((resNeg ^ overRange) | resZero);
      resGe = ~(resNeg ^ overRange);
      trueSign = resNeg ^ overRange;
      destGuarded = isGuarded(issue.destMain);
      // Saturation clamps to the main destination's range
      writeVal = result;
      if (state_reg.saturateEnable)
      begin
         if (destGuarded && overRange)
         begin
            writeVal = trueSign ? {1'b1, {(FULL_W-1){1'b0}}}
               : {1'b0, {(FULL_W-1){1'b1}}};
         end
         else if (!destGuarded && (overBase || overRange))
         begin
            writeVal = trueSign ? {{(GUARD_W+1){1'b1}}, {(BASE_W-1){1'b0}}}
               : {{(GUARD_W+1){1'b0}}, {(BASE_W-1){1'b1}}};
         end
      end
   end

   // ==========================================================
   // Flag generation
   always_comb
   begin
      newFlags.neg = resNeg;
      newFlags.zero = resZero;
      newFlags.ovf = overBase;
      newFlags.greater = resGt;
      case (state_reg.condSelect)
         CS_CARRY: newFlags.cond = baseCarry;
         CS_NEG: newFlags.cond = resNeg;
         CS_ZERO: newFlags.cond = resZero;
         CS_OVF: newFlags.cond = overBase;
         CS_GT: newFlags.cond = resGt;
         CS_GE: newFlags.cond = resGe;
         default: newFlags.cond = 1'b0;
      endcase
      if (issue.op == DSP_ADD_CARRY || issue.op == DSP_SUB_BORROW)
      begin
         newFlags.cond = baseCarry;
      end
   end

   // ==========================================================
   // Issue decode
   always_comb
   begin
      xSlotUsed = issue.valid
         && (issue.word[X_SLOT_LSB +: SLOT_W] != SLOT_EMPTY);
      ySlotUsed = issue.valid
         && (issue.word[Y_SLOT_LSB +: SLOT_W] != SLOT_EMPTY);
      execute = issue.valid
         && (!issue.conditional || (state_reg.flags.cond ^ issue.condOnFalse));
      updateFlags = issue.valid && !issue.conditional;
   end

   // ==========================================================
   // Next state
   logic busHit;
   logic [7:0] busAdr;

   always_comb
   begin
      state_next = state_reg;
      busAdr = wb_adr_i[7:0];
      busHit = wb_cyc_i && wb_stb_i;

      // Arithmetic writeback in the memory-access stage
      if (execute && issue.op != DSP_COMPARE)
      begin
         if (destGuarded)
         begin
            state_next.regs[issue.destMain] = writeVal;
         end
         else
         begin
            state_next.regs[issue.destMain] = {{GUARD_W{1'b0}},
               writeVal[BASE_W-1:0]};
         end
         if (issue.auxEn && (issue.op == DSP_ADD || issue.op == DSP_SUB))
         begin
            if (isGuarded(mapAux(issue.destAux)))
            begin
               state_next.regs[mapAux(issue.destAux)] = writeVal;
            end
            else
            begin
               state_next.regs[mapAux(issue.destAux)] = {{GUARD_W{1'b0}},
                  writeVal[BASE_W-1:0]};
            end
         end
      end
      if (updateFlags)
      begin
         state_next.flags = newFlags;
      end

      // Parallel loads, after the arithmetic has read its sources
      if (xSlotUsed)
      begin
         state_next.regs[xfer.xTarget] = loadWord(xfer.xData);
      end
      if (ySlotUsed)
      begin
         state_next.regs[xfer.yTarget] = loadWord(xfer.yData);
      end

      // Register bus: ack one cycle after the request, dropped after one
      state_next.ack = busHit && !state_reg.ack;
      if (busHit && !state_reg.ack)
      begin
         state_next.rdata = '0;
         if (busAdr == OFS_CTRL)
         begin
            state_next.rdata[CTRL_CS_LSB +: 3] = state_reg.condSelect;
            state_next.rdata[CTRL_SAT_BIT] = state_reg.saturateEnable;
         end
         else if (busAdr == OFS_FLAGS)
         begin
            state_next.rdata[FLG_COND_BIT] = state_reg.flags.cond;
            state_next.rdata[FLG_NEG_BIT] = state_reg.flags.neg;
            state_next.rdata[FLG_ZERO_BIT] = state_reg.flags.zero;
            state_next.rdata[FLG_OVF_BIT] = state_reg.flags.ovf;
            state_next.rdata[FLG_GT_BIT] = state_reg.flags.greater;
         end
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (busAdr == OFS_REG_BASE + 8'(4 * i))
            begin
               state_next.rdata = state_reg.regs[i][BASE_W-1:0];
            end
         end
         for (int i = 0; i < NUM_GUARDED; i++)
         begin
            if (busAdr == OFS_GUARD_BASE + 8'(4 * i))
            begin
               state_next.rdata = {{(BASE_W-GUARD_W){1'b0}},
                  state_reg.regs[i][FULL_W-1:BASE_W]};
            end
         end
         if (wb_adr_i[ADDR_W-1:0] != {{(ADDR_W-8){1'b0}}, busAdr})
         begin
            state_next.rdata = '0;
         end
      end
      if (busHit && state_reg.ack && wb_we_i && wb_sel_i[0]
         && wb_adr_i[ADDR_W-1:0] == {{(ADDR_W-8){1'b0}}, OFS_CTRL})
      begin
         state_next.condSelect = wb_dat_i[CTRL_CS_LSB +: 3];
         state_next.saturateEnable = wb_dat_i[CTRL_SAT_BIT];
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_reg.regs <= '0;
         state_reg.flags <= '0;
         state_reg.condSelect <= CS_RESET;
         state_reg.saturateEnable <= CTRL_SAT_RESET;
         state_reg.ack <= 1'b0;
         state_reg.rdata <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs
   assign flagsOut = state_reg.flags;
   assign saturateEnable = state_reg.saturateEnable;
   assign wb_dat_o = state_reg.rdata;
   assign wb_ack_o = state_reg.ack;

endmodule

/* File: src/dfpa_pkg.sv */
package dfpa_pkg;

   // ==========================================================
   // Datapath widths
   localparam int BASE_W = 32;
   localparam int GUARD_W = 8;
   localparam int FULL_W = 40;
   localparam int HALF_W = 16;
   localparam int NUM_REGS = 8;
   localparam int NUM_GUARDED = 2;

   // ==========================================================
   // Condition select codes
   localparam logic [2:0] CS_CARRY = 3'h0;
   localparam logic [2:0] CS_NEG = 3'h1;
   localparam logic [2:0] CS_ZERO = 3'h2;
   localparam logic [2:0] CS_OVF = 3'h3;
   localparam logic [2:0] CS_GT = 3'h4;
   localparam logic [2:0] CS_GE = 3'h5;
   localparam logic [2:0] CS_RESET = 3'h0;

   // ==========================================================
   // Transfer slot fields of the issued instruction word
   localparam int X_SLOT_LSB = 2;
   localparam int Y_SLOT_LSB = 0;
   localparam int SLOT_W = 2;
   localparam logic [1:0] SLOT_EMPTY = 2'h0;

   // ==========================================================
   // Register bus map, byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FLAGS = 8'h04;
   localparam logic [7:0] OFS_REG_BASE = 8'h10;
   localparam logic [7:0] OFS_GUARD_BASE = 8'h30;
   localparam int CTRL_CS_LSB = 0;
   localparam int CTRL_SAT_BIT = 4;
   localparam logic CTRL_SAT_RESET = 1'b0;
   localparam int FLG_COND_BIT = 0;
   localparam int FLG_NEG_BIT = 1;
   localparam int FLG_ZERO_BIT = 2;
   localparam int FLG_OVF_BIT = 3;
   localparam int FLG_GT_BIT = 4;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      DSP_ADD, DSP_SUB, DSP_ADD_CARRY, DSP_SUB_BORROW, DSP_COMPARE,
      DSP_COPY, DSP_ABS, DSP_NEG, DSP_CLEAR
   } dfpa_op_e;

   typedef enum logic [2:0] {
      ACC_REG_0, ACC_REG_1, MUL_IN_REG_0, MUL_IN_REG_1,
      XIN_REG_0, XIN_REG_1, YIN_REG_0, YIN_REG_1
   } dfpa_reg_e;

   typedef struct packed {
      logic cond;
      logic neg;
      logic zero;
      logic ovf;
      logic greater;
   } dfpa_flags_s;

   typedef struct packed {
      logic valid;
      logic [HALF_W-1:0] word;
      dfpa_op_e op;
      logic [1:0] firstSource;
      logic [1:0] secondSource;
      logic useSecond;
      dfpa_reg_e destMain;
      logic [1:0] destAux;
      logic auxEn;
      logic conditional;
      logic condOnFalse;
   } dfpa_issue_s;

   typedef struct packed {
      dfpa_reg_e xTarget;
      logic [HALF_W-1:0] xData;
      dfpa_reg_e yTarget;
      logic [HALF_W-1:0] yData;
   } dfpa_xfer_s;

   typedef struct packed {
      logic [NUM_REGS-1:0][FULL_W-1:0] regs;
      dfpa_flags_s flags;
      logic [2:0] condSelect;
      logic saturateEnable;
      logic ack;
      logic [BASE_W-1:0] rdata;
   } dfpa_state_s;

endpackage

/* File: verif/dfpa_alu_flags_asserts.sv */
module dfpa_alu_flags_asserts
   import dfpa_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire dfpa_issue_s issue,
   input wire dfpa_flags_s flagsOut,
   input wire logic saturateEnable,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [BASE_W-1:0] wb_dat_i,
   input wire logic wb_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========
   // Shadow of the control register
   typedef struct packed {
      logic [2:0] condSel;
      logic sat;
   } dfpa_shadow_s;
   dfpa_shadow_s shadow_reg;
   dfpa_shadow_s shadow_next;
   logic ctrlWr;
   logic upd;
   logic plain;
   assign ctrlWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
      && wb_adr_i == ADDR_W'(OFS_CTRL);
   assign upd = issue.valid && !issue.conditional;
   assign plain = upd && issue.op != DSP_ADD_CARRY && issue.op != DSP_SUB_BORROW;
   always_comb
   begin
      shadow_next = shadow_reg;
      if (ctrlWr)
      begin
         shadow_next.condSel = wb_dat_i[2:0];
         shadow_next.sat = wb_dat_i[CTRL_SAT_BIT];
      end
   end
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         shadow_reg <= '0;
      else
         shadow_reg <= shadow_next;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // =========
   // Properties
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack too long");
   a_flags_hold: assert property (!issue.valid || issue.conditional |=> $stable(flagsOut))
      else $error("flags moved without update");
   a_neg_mirror: assert property (plain && shadow_reg.condSel == CS_NEG |=> flagsOut.cond == flagsOut.neg)
      else $error("negative mode mismatch");
   a_zero_mirror: assert property (plain && shadow_reg.condSel == CS_ZERO |=> flagsOut.cond == flagsOut.zero)
      else $error("zero mode mismatch");
   a_ovf_mirror: assert property (plain && shadow_reg.condSel == CS_OVF |=> flagsOut.cond == flagsOut.ovf)
      else $error("overflow mode mismatch");
   a_gt_mirror: assert property (plain && shadow_reg.condSel == CS_GT |=> flagsOut.cond == flagsOut.greater)
      else $error("greater mode mismatch");
   a_reserved_clear: assert property (plain && shadow_reg.condSel[2:1] == 2'b11 |=> !flagsOut.cond)
      else $error("reserved mode flag set");
   a_gt_not_zero: assert property (upd |=> !(flagsOut.greater && flagsOut.zero))
      else $error("greater with zero result");
   a_ge_on_equal: assert property (upd && issue.op == DSP_COMPARE && shadow_reg.condSel == CS_GE |=> !flagsOut.zero || flagsOut.cond)
      else $error("equal compare not ge");
   a_sat_echo: assert property (saturateEnable == shadow_reg.sat)
      else $error("saturate bit mismatch");
   c_compare: cover property (issue.valid && issue.op == DSP_COMPARE);
   c_conditional: cover property (issue.valid && issue.conditional);
   c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind dfpa_alu_flags dfpa_alu_flags_asserts #(.ADDR_W(ADDR_W)) dfpa_alu_flags_asserts_inst (
   .clock(clock), .sys_rst(sys_rst), .issue(issue), .flagsOut(flagsOut),
   .saturateEnable(saturateEnable), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o)
);

/* File: verif/dfpa_core_model.sv */
module dfpa_core_model
   import dfpa_pkg::*;
(
   input wire logic clock,
   output dfpa_issue_s issue,
   output dfpa_xfer_s xfer
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      issue = '0;
      xfer = '0;
   end
   // One instruction per stage; transfer data goes stale afterwards
   task automatic send(input dfpa_issue_s i, input dfpa_xfer_s x);
      @(posedge clock);
      issue <= i;
      xfer <= x;
      @(posedge clock);
      issue <= '0;
      xfer.xData <= ~x.xData;
      xfer.yData <= ~x.yData;
   endtask
endmodule

/* File: verif/dfpa_alu_flags_tb.sv */
module dfpa_alu_flags_tb
   import dfpa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock;
   logic sys_rst = 1'b1;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = '0;
   logic [3:0] wbSel = '0;
   logic [31:0] wbDatI = '0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic sat = 1'b0;
   dfpa_issue_s issue;
   dfpa_xfer_s xfer;
   dfpa_flags_s flagsOut;
   logic saturateEnable;
   dfpa_issue_s iss;
   dfpa_xfer_s xf = '0;
   int fails = 0;
   int nCompared = 0;

   dfpa_alu_flags #(.ADDR_W(8)) dfpa_alu_flags_inst (
      .clock(clock), .sys_rst(sys_rst), .issue(issue), .xfer(xfer), .flagsOut(flagsOut),
      .saturateEnable(saturateEnable), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck)
   );
   dfpa_core_model dfpa_core_model_inst (.clock(clock), .issue(issue), .xfer(xfer));

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // =========
   // Bus and issue tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbSel <= 4'hF;
      wbDatI <= d;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (wbAck !== 1'b1 && n < 16);
      if (wbAck !== 1'b1)
         fails++;
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk($sformatf("read %h", a), q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rr(input dfpa_reg_e r, input logic [31:0] e);
      rd(OFS_REG_BASE + 8'(4 * r), e);
   endtask
   function automatic dfpa_issue_s mk(input dfpa_op_e o, input logic [1:0] f,
                                      input logic [1:0] s, input logic u, input dfpa_reg_e d);
      mk = '0;
      mk.valid = 1'b1;
      mk.word = 16'hF800;
      mk.op = o;
      mk.firstSource = f;
      mk.secondSource = s;
      mk.useSecond = u;
      mk.destMain = d;
   endfunction
   task automatic op(input dfpa_issue_s i, input logic [2:0] cs, input logic [4:0] ef);
      logic [31:0] c;
      logic [31:0] f;
      c = '0;
      c[2:0] = cs;
      c[CTRL_SAT_BIT] = sat;
      wr(OFS_CTRL, c);
      dfpa_core_model_inst.send(i, xf);
      rd(OFS_FLAGS, {27'h0, ef});
      f = {27'h0, flagsOut.greater, flagsOut.ovf, flagsOut.zero, flagsOut.neg, flagsOut.cond};
      chk("flagsOut", f, {27'h0, ef});
   endtask
   task tally_and_finish;
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (50000) @(posedge clock);
      fails++;
      tally_and_finish();
   end
   // =========
   // Test sequence
   initial
   begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      rd(OFS_CTRL, 32'h0);
      wr(OFS_FLAGS, 32'h1F);
      wr(8'h80, 32'hFFFF_FFFF);
      rd(OFS_FLAGS, 32'h0);
      rd(8'h80, 32'h0);
      iss = mk(DSP_CLEAR, 2'h0, 2'h0, 1'b0, ACC_REG_0);
      iss.conditional = 1'b1;
      iss.word = 16'hF80B;
      xf = '{XIN_REG_0, 16'h4000, YIN_REG_1, 16'hC000};
      op(iss, CS_CARRY, 5'h00);
      rr(XIN_REG_0, 32'h4000_0000);
      rr(YIN_REG_1, 32'hC000_0000);
      iss.word = 16'hF803;
      xf = '{XIN_REG_1, 16'h5555, YIN_REG_0, 16'h4000};
      op(iss, CS_CARRY, 5'h00);
      rr(XIN_REG_1, 32'h0);
      rr(YIN_REG_0, 32'h4000_0000);
      xf = '0;
      op(mk(DSP_ADD, 2'h2, 2'h0, 1'b0, ACC_REG_0), CS_CARRY, 5'h18);
      rr(ACC_REG_0, 32'h8000_0000);
      rd(OFS_GUARD_BASE, 32'h0);
      op(mk(DSP_ADD, 2'h2, 2'h1, 1'b0, ACC_REG_1), CS_CARRY, 5'h05);
      op(mk(DSP_NEG, 2'h2, 2'h0, 1'b0, ACC_REG_1), CS_NEG, 5'h03);
      rd(OFS_GUARD_BASE + 8'h4, 32'hFF);
      op(mk(DSP_CLEAR, 2'h0, 2'h0, 1'b0, ACC_REG_1), CS_ZERO, 5'h05);
      rd(OFS_GUARD_BASE + 8'h4, 32'h0);
      op(mk(DSP_ADD, 2'h0, 2'h0, 1'b0, XIN_REG_1), CS_OVF, 5'h19);
      rr(XIN_REG_1, 32'hC000_0000);
      op(mk(DSP_COPY, 2'h3, 2'h0, 1'b0, ACC_REG_1), CS_NEG, 5'h03);
      rd(OFS_GUARD_BASE + 8'h4, 32'hFF);
      op(mk(DSP_COMPARE, 2'h2, 2'h1, 1'b0, ACC_REG_1), CS_GT, 5'h19);
      rr(ACC_REG_1, 32'hC000_0000);
      op(mk(DSP_COMPARE, 2'h2, 2'h0, 1'b0, ACC_REG_1), CS_GE, 5'h05);
      for (int k = 6; k < 8; k++)
         op(mk(DSP_ADD, 2'h2, 2'h0, 1'b0, MUL_IN_REG_0), 3'(k), 5'h18);
      op(mk(DSP_ADD_CARRY, 2'h2, 2'h1, 1'b0, MUL_IN_REG_1), CS_NEG, 5'h05);
      op(mk(DSP_SUB_BORROW, 2'h2, 2'h0, 1'b0, MUL_IN_REG_1), CS_ZERO, 5'h03);
      rr(MUL_IN_REG_1, 32'hFFFF_FFFF);
      op(mk(DSP_ABS, 2'h0, 2'h1, 1'b1, ACC_REG_1), CS_CARRY, 5'h11);
      rr(ACC_REG_1, 32'h4000_0000);
      iss = mk(DSP_SUB, 2'h2, 2'h0, 1'b0, MUL_IN_REG_0);
      iss.auxEn = 1'b1;
      iss.destAux = 2'h1;
      op(iss, CS_CARRY, 5'h04);
      rr(ACC_REG_1, 32'h0);
      iss.op = DSP_COPY;
      iss.destAux = 2'h0;
      op(iss, CS_CARRY, 5'h10);
      rr(ACC_REG_0, 32'h8000_0000);
      iss = mk(DSP_SUB, 2'h2, 2'h1, 1'b0, ACC_REG_1);
      iss.conditional = 1'b1;
      iss.condOnFalse = 1'b1;
      op(iss, CS_CARRY, 5'h10);
      rr(ACC_REG_1, 32'h8000_0000);
      iss.condOnFalse = 1'b0;
      iss.destMain = MUL_IN_REG_1;
      iss.word = 16'hF808;
      xf = '{XIN_REG_1, 16'h7000, YIN_REG_0, 16'h0};
      op(iss, CS_CARRY, 5'h10);
      rr(MUL_IN_REG_1, 32'hFFFF_FFFF);
      rr(XIN_REG_1, 32'h7000_0000);
      xf = '0;
      sat = 1'b1;
      op(mk(DSP_ADD, 2'h0, 2'h0, 1'b0, XIN_REG_1), CS_CARRY, 5'h18);
      rr(XIN_REG_1, 32'h7FFF_FFFF);
      rd(OFS_CTRL, 32'h10);
      chk("saturateEnable", {31'h0, saturateEnable}, 32'h1);
      sat = 1'b0;
      iss = mk(DSP_ADD, 2'h2, 2'h0, 1'b0, ACC_REG_1);
      iss.word = 16'hF808;
      xf = '{XIN_REG_0, 16'h1234, YIN_REG_0, 16'h0};
      op(iss, CS_CARRY, 5'h18);
      rr(ACC_REG_1, 32'h8000_0000);
      rr(XIN_REG_0, 32'h1234_0000);
      tally_and_finish();
   end
endmodule
